// *** verilog/operand_address_generator.sv ***
// effective address generation with circular and bit-reversed modes
`timescale 1ns/1ps
module operand_address_generator #(
   parameter int ADDR_W = 8,
   parameter int W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic req_valid,
   input wire agu_pkg::class_t req_class,
   input wire agu_pkg::unit_t req_unit,
   input wire agu_pkg::mode_t req_mode,
   input wire logic [3:0] req_reg,
   input wire logic [W-1:0] req_ptr,
   input wire logic [W-1:0] req_index,
   input wire logic [W-1:0] req_mod,
   input wire logic req_byte,
   input wire logic req_interrupt_disable_instruction,
   input wire logic [W-1:0] req_lit,
   output logic ea_valid,
   output logic [W-1:0] ea,
   output agu_pkg::unit_t ea_unit,
   output logic ea_error,
   output logic wb_en,
   output logic [3:0] wb_reg,
   output logic [W-1:0] wb_value,
   output logic lit_valid,
   output logic [W-1:0] lit_value
);

   // ---------------------------------------------------------------
   // registers and internal signals
   // ---------------------------------------------------------------
   logic [W-1:0] ctrl_r;
   logic [W-1:0] x_start_r;
   logic [W-1:0] x_end_r;
   logic [W-1:0] y_start_r;
   logic [W-1:0] y_end_r;
   logic [W-1:0] rev_ctrl_r;
   logic [W-1:0] last_ea_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic ea_valid_r;
   logic [W-1:0] ea_r;
   agu_pkg::unit_t ea_unit_r;
   logic ea_error_r;
   logic wb_en_r;
   logic [3:0] wb_reg_r;
   logic [W-1:0] wb_value_r;
   logic lit_valid_r;
   logic [W-1:0] lit_value_r;

   logic aw_go;
   logic ar_go;
   logic wr_fire;
   logic wr_hit;
   logic [W-1:0] wr_merged;
   logic [3:0] x_sel;
   logic [3:0] y_sel;
   logic [3:0] rev_sel;
   logic x_mod_on;
   logic y_mod_on;
   logic rev_on;
   logic mod_en;
   logic mac_step_ok;
   agu_pkg::unit_t unit_c;
   logic err_c;
   logic [W-1:0] sum_c;
   logic [W-1:0] corr_c;
   logic [W-1:0] rev_new_c;
   logic [W-1:0] rev_step_c;
   logic [W-1:0] ea_c;
   logic [W-1:0] new_ptr_c;
   logic wb_c;
   logic [W-1:0] sel_start;
   logic [W-1:0] sel_end;

   function automatic logic [W-1:0] bit_rev(input logic [W-1:0] v);
      logic [W-1:0] r;
      r = '0;
      for (int i = 0; i < W; i++) begin
         r[i] = v[W-1-i];
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // register bus: write channel
   // ---------------------------------------------------------------
   // address and data are taken together, one write in flight
   assign aw_go = awvalid && wvalid && !awready_r && !bvalid_r;
   assign wr_fire = awready_r;

   always_comb begin
      wr_hit = 1'b1;
      case (awaddr)
         agu_pkg::CTRL_OFF: wr_merged = ctrl_r;
         agu_pkg::X_START_OFF: wr_merged = x_start_r;
         agu_pkg::X_END_OFF: wr_merged = x_end_r;
         agu_pkg::Y_START_OFF: wr_merged = y_start_r;
         agu_pkg::Y_END_OFF: wr_merged = y_end_r;
         agu_pkg::REV_CTRL_OFF: wr_merged = rev_ctrl_r;
         agu_pkg::LAST_EA_OFF: wr_merged = last_ea_r;
         default: begin
            wr_merged = '0;
            wr_hit = 1'b0;
         end
      endcase
      if (wstrb[0]) begin
         wr_merged[7:0] = wdata[7:0];
      end
      if (wstrb[1]) begin
         wr_merged[15:8] = wdata[15:8];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b0;
         wready_r <= 1'b0;
      end else begin
         awready_r <= aw_go;
         wready_r <= aw_go;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= agu_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? agu_pkg::RESP_OKAY : agu_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // buffer bounds and control, 16 bits in the low lanes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= agu_pkg::CTRL_RST;
         x_start_r <= agu_pkg::BUF_ADDR_RST;
         x_end_r <= agu_pkg::BUF_ADDR_RST;
         y_start_r <= agu_pkg::BUF_ADDR_RST;
         y_end_r <= agu_pkg::BUF_ADDR_RST;
         rev_ctrl_r <= agu_pkg::REV_CTRL_RST;
      end else if (wr_fire) begin
         case (awaddr)
            agu_pkg::CTRL_OFF: ctrl_r <= wr_merged;
            agu_pkg::X_START_OFF: x_start_r <= wr_merged;
            agu_pkg::X_END_OFF: x_end_r <= wr_merged;
            agu_pkg::Y_START_OFF: y_start_r <= wr_merged;
            agu_pkg::Y_END_OFF: y_end_r <= wr_merged;
            agu_pkg::REV_CTRL_OFF: rev_ctrl_r <= wr_merged;
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // register bus: read channel
   // ---------------------------------------------------------------
   assign ar_go = arvalid && !arready_r && !rvalid_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
      end else begin
         arready_r <= ar_go;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rresp_r <= agu_pkg::RESP_OKAY;
         rdata_r <= '0;
      end else if (arready_r) begin
         rvalid_r <= 1'b1;
         rresp_r <= agu_pkg::RESP_OKAY;
         case (araddr)
            agu_pkg::CTRL_OFF: rdata_r <= {16'h0000, ctrl_r};
            agu_pkg::X_START_OFF: rdata_r <= {16'h0000, x_start_r};
            agu_pkg::X_END_OFF: rdata_r <= {16'h0000, x_end_r};
            agu_pkg::Y_START_OFF: rdata_r <= {16'h0000, y_start_r};
            agu_pkg::Y_END_OFF: rdata_r <= {16'h0000, y_end_r};
            agu_pkg::REV_CTRL_OFF: rdata_r <= {16'h0000, rev_ctrl_r};
            agu_pkg::LAST_EA_OFF: rdata_r <= {16'h0000, last_ea_r};
            default: begin
               rdata_r <= '0;
               rresp_r <= agu_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // mode enables
   // ---------------------------------------------------------------
   assign x_sel = ctrl_r[agu_pkg::X_SEL_LSB +: agu_pkg::SEL_W];
   assign y_sel = ctrl_r[agu_pkg::Y_SEL_LSB +: agu_pkg::SEL_W];
   assign rev_sel = ctrl_r[agu_pkg::REV_SEL_LSB +: agu_pkg::SEL_W];
   // select 15 switches modulo off for the space
   assign x_mod_on = ctrl_r[agu_pkg::X_EN_BIT] && (x_sel != agu_pkg::SEL_NONE);
   assign y_mod_on = ctrl_r[agu_pkg::Y_EN_BIT] && (y_sel != agu_pkg::SEL_NONE);

   // word writes through X write unit, pre/post increment only
   assign rev_on = rev_ctrl_r[agu_pkg::REV_EN_BIT]
      && (rev_sel != agu_pkg::SEL_NONE) && (req_reg == rev_sel)
      && (unit_c == agu_pkg::UNIT_X_WRITE) && !req_byte && !req_mod[W-1]
      && (req_mode == agu_pkg::MODE_PRE || req_mode == agu_pkg::MODE_POST);

   // one buffer per space, X covering the X write unit too
   always_comb begin
      if (unit_c == agu_pkg::UNIT_Y) begin
         mod_en = y_mod_on && (req_reg == y_sel);
         sel_start = y_start_r;
         sel_end = y_end_r;
      end else begin
         // bit-reverse wins in X write, X read keeps modulo
         mod_en = x_mod_on && (req_reg == x_sel) && !rev_on;
         sel_start = x_start_r;
         sel_end = x_end_r;
      end
   end

   // ---------------------------------------------------------------
   // request checking and routing
   // ---------------------------------------------------------------
   assign mac_step_ok = (req_mod == agu_pkg::MAC_STEP_2)
      || (req_mod == agu_pkg::MAC_STEP_4) || (req_mod == agu_pkg::MAC_STEP_6)
      || (req_mod == agu_pkg::MAC_STEP_M2)
      || (req_mod == agu_pkg::MAC_STEP_M4)
      || (req_mod == agu_pkg::MAC_STEP_M6);

   always_comb begin
      unit_c = req_unit;
      err_c = 1'b0;
      if (req_class == agu_pkg::CLS_MAC) begin
         if (req_reg == agu_pkg::MAC_X_LO || req_reg == agu_pkg::MAC_X_IDX) begin
            unit_c = agu_pkg::UNIT_X_READ;
         end else begin
            unit_c = agu_pkg::UNIT_Y;
         end
         if (req_reg < agu_pkg::MAC_X_LO || req_reg > agu_pkg::MAC_Y_IDX) begin
            err_c = 1'b1;
         end
         case (req_mode)
            agu_pkg::MODE_IND: ;
            agu_pkg::MODE_POST: begin
               err_c = err_c || !mac_step_ok;
            end
            agu_pkg::MODE_REG_OFS: begin
               if (req_reg != agu_pkg::MAC_X_IDX
                  && req_reg != agu_pkg::MAC_Y_IDX) begin
                  err_c = 1'b1;
               end
            end
            default: err_c = 1'b1;
         endcase
      end else if (req_class == agu_pkg::CLS_MCU
         && req_mode == agu_pkg::MODE_REG_OFS) begin
         err_c = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // address arithmetic
   // ---------------------------------------------------------------
   always_comb begin
      case (req_mode)
         agu_pkg::MODE_POST: sum_c = req_ptr + req_mod;
         agu_pkg::MODE_PRE: sum_c = req_ptr + req_mod;
         // single shared index value, whichever operand uses it
         agu_pkg::MODE_REG_OFS: sum_c = req_ptr + req_index;
         agu_pkg::MODE_LIT_OFS: sum_c = req_ptr + req_mod;
         default: sum_c = req_ptr;
      endcase
   end

   modulo_corrector #(
      .W(W)
   ) u_corrector (
      .addr(sum_c),
      .start_addr(sel_start),
      .end_addr(sel_end),
      .enable(mod_en),
      .word_only(mod_en && (unit_c == agu_pkg::UNIT_Y)),
      .result(corr_c)
   );

   // reverse-carry add: pointer and word-scaled modifier are both reversed
   assign rev_step_c = {rev_ctrl_r[agu_pkg::REV_MOD_MSB:0], 1'b0};
   assign rev_new_c = bit_rev(bit_rev(req_ptr) + bit_rev(rev_step_c));

   always_comb begin
      new_ptr_c = rev_on ? {rev_new_c[W-1:1], 1'b0} : corr_c;
      case (req_mode)
         agu_pkg::MODE_POST: begin
            ea_c = rev_on ? {req_ptr[W-1:1], 1'b0} : req_ptr;
            wb_c = 1'b1;
         end
         agu_pkg::MODE_PRE: begin
            ea_c = new_ptr_c;
            wb_c = 1'b1;
         end
         agu_pkg::MODE_IND: begin
            ea_c = corr_c;
            wb_c = 1'b0;
         end
         default: begin
            // offset forms correct the address, pointer left alone
            ea_c = corr_c;
            wb_c = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // result registers
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ea_valid_r <= 1'b0;
         ea_error_r <= 1'b0;
         wb_en_r <= 1'b0;
         ea_r <= '0;
         ea_unit_r <= agu_pkg::UNIT_X_READ;
         wb_reg_r <= '0;
         wb_value_r <= '0;
      end else begin
         ea_valid_r <= 1'b0;
         ea_error_r <= 1'b0;
         wb_en_r <= 1'b0;
         if (req_valid && req_class != agu_pkg::CLS_OTHER) begin
            ea_valid_r <= !err_c;
            ea_error_r <= err_c;
            wb_en_r <= wb_c && !err_c;
            ea_r <= ea_c;
            ea_unit_r <= unit_c;
            wb_reg_r <= req_reg;
            wb_value_r <= new_ptr_c;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_ea_r <= '0;
      end else if (req_valid && req_class != agu_pkg::CLS_OTHER && !err_c) begin
         last_ea_r <= ea_c;
      end
   end

   // jump displacement passes signed; interrupt-disable count zero-filled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lit_valid_r <= 1'b0;
         lit_value_r <= '0;
      end else begin
         lit_valid_r <= req_valid && (req_class == agu_pkg::CLS_OTHER);
         if (req_valid && req_class == agu_pkg::CLS_OTHER) begin
            lit_value_r <= req_interrupt_disable_instruction
               ? {{(W-agu_pkg::INTERRUPT_DISABLE_INSTRUCTION_LIT_W){1'b0}},
                  req_lit[agu_pkg::INTERRUPT_DISABLE_INSTRUCTION_LIT_W-1:0]}
               : req_lit;
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rresp = rresp_r;
   assign rdata = rdata_r;
   assign ea_valid = ea_valid_r;
   assign ea = ea_r;
   assign ea_unit = ea_unit_r;
   assign ea_error = ea_error_r;
   assign wb_en = wb_en_r;
   assign wb_reg = wb_reg_r;
   assign wb_value = wb_value_r;
   assign lit_valid = lit_valid_r;
   assign lit_value = lit_value_r;

endmodule // operand_address_generator

// *** inc/agu_pkg.sv ***
// constants and types shared by the operand address generator
package agu_pkg;

   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] X_START_OFF = 8'h04;
   localparam logic [7:0] X_END_OFF = 8'h08;
   localparam logic [7:0] Y_START_OFF = 8'h0c;
   localparam logic [7:0] Y_END_OFF = 8'h10;
   localparam logic [7:0] REV_CTRL_OFF = 8'h14;
   localparam logic [7:0] LAST_EA_OFF = 8'h18;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int X_SEL_LSB = 0;
   localparam int Y_SEL_LSB = 4;
   localparam int REV_SEL_LSB = 8;
   localparam int SEL_W = 4;
   localparam int X_EN_BIT = 15;
   localparam int Y_EN_BIT = 14;
   localparam int REV_EN_BIT = 15;
   localparam int REV_MOD_MSB = 14;
   localparam logic [3:0] SEL_NONE = 4'hf;
   localparam logic [15:0] CTRL_RST = 16'h0fff;
   localparam logic [15:0] REV_CTRL_RST = 16'h0000;
   localparam logic [15:0] BUF_ADDR_RST = 16'h0000;

   // ---------------------------------------------------------------
   // pointer registers and steps of the multiply-accumulate class, and the interrupt-disable literal width
   // ---------------------------------------------------------------
   localparam logic [3:0] MAC_X_LO = 4'h8;
   localparam logic [3:0] MAC_X_IDX = 4'h9;
   localparam logic [3:0] MAC_Y_LO = 4'ha;
   localparam logic [3:0] MAC_Y_IDX = 4'hb;
   localparam logic [15:0] MAC_STEP_2 = 16'h0002;
   localparam logic [15:0] MAC_STEP_4 = 16'h0004;
   localparam logic [15:0] MAC_STEP_6 = 16'h0006;
   localparam logic [15:0] MAC_STEP_M2 = 16'hfffe;
   localparam logic [15:0] MAC_STEP_M4 = 16'hfffc;
   localparam logic [15:0] MAC_STEP_M6 = 16'hfffa;
   localparam int INTERRUPT_DISABLE_INSTRUCTION_LIT_W = 14;

   // ---------------------------------------------------------------
   // bus answers
   // ---------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ---------------------------------------------------------------
   // request encodings
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_IND = 3'd0,
      MODE_POST = 3'd1,
      MODE_PRE = 3'd2,
      MODE_REG_OFS = 3'd3,
      MODE_LIT_OFS = 3'd4
   } mode_t;
   typedef enum logic [1:0] {
      CLS_MCU = 2'd0,
      CLS_MOVE_ACC = 2'd1,
      CLS_MAC = 2'd2,
      CLS_OTHER = 2'd3
   } class_t;
   typedef enum logic [1:0] {
      UNIT_X_READ = 2'd0,
      UNIT_X_WRITE = 2'd1,
      UNIT_Y = 2'd2
   } unit_t;

endpackage

// *** verilog/modulo_corrector.sv ***
// circular buffer boundary correction of one address
`timescale 1ns/1ps
module modulo_corrector #(
   parameter int W = 16
) (
   input wire logic [W-1:0] addr,
   input wire logic [W-1:0] start_addr,
   input wire logic [W-1:0] end_addr,
   input wire logic enable,
   input wire logic word_only,
   output logic [W-1:0] result
);

   localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

   // length comes only from start and end, up to the full 16-bit span
   always_comb begin
      result = addr;
      if (enable) begin
         // compare, not equality, so large steps still wrap
         if (addr > end_addr) begin
            result = start_addr + (addr - end_addr - ONE);
         end else if (addr < start_addr) begin
            result = end_addr - (start_addr - addr - ONE);
         end
      end
      if (word_only) begin
         result[0] = 1'b0;
      end
   end

endmodule // modulo_corrector

// *** testbench/agu_chk.sv ***
// port assertions for the operand address generator
`timescale 1ns/1ps
module agu_chk #(
   parameter int W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic req_valid,
   input wire agu_pkg::class_t req_class,
   input wire agu_pkg::mode_t req_mode,
   input wire logic [3:0] req_reg,
   input wire logic [W-1:0] req_ptr,
   input wire logic req_interrupt_disable_instruction,
   input wire logic [W-1:0] req_lit,
   input wire logic ea_valid,
   input wire logic [W-1:0] ea,
   input wire agu_pkg::unit_t ea_unit,
   input wire logic ea_error,
   input wire logic wb_en,
   input wire logic lit_valid,
   input wire logic [W-1:0] lit_value
);
   // ----
   // request classes
   // ----
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire logic mac = req_valid && req_class == agu_pkg::CLS_MAC;
   wire logic lit = req_valid && req_class == agu_pkg::CLS_OTHER;
   wire logic mv = req_valid && req_class == agu_pkg::CLS_MOVE_ACC;
   wire logic mcu = req_valid && req_class == agu_pkg::CLS_MCU;
   wire logic ind = req_mode == agu_pkg::MODE_IND;
   wire logic ofs = req_mode == agu_pkg::MODE_REG_OFS;
   property p_mac_x;
      mac && ind && req_reg inside {4'h8, 4'h9} |=>
         ea_valid && ea_unit == agu_pkg::UNIT_X_READ;
   endproperty
   a_mac_x: assert property (p_mac_x) else $error("mac x unit");
   property p_mac_y;
      mac && ind && req_reg inside {4'ha, 4'hb} |=>
         ea_valid && ea_unit == agu_pkg::UNIT_Y;
   endproperty
   a_mac_y: assert property (p_mac_y) else $error("mac y unit");
   property p_mac_reg;
      mac && !(req_reg inside {[4'h8:4'hb]}) |=> ea_error && !ea_valid;
   endproperty
   a_mac_reg: assert property (p_mac_reg) else $error("mac reg");
   property p_mac_idx;
      mac && ofs && req_reg inside {4'h8, 4'ha} |=> ea_error;
   endproperty
   a_mac_idx: assert property (p_mac_idx) else $error("mac idx");
   property p_mac_pre;
      mac && req_mode == agu_pkg::MODE_PRE |=> ea_error && !wb_en;
   endproperty
   a_mac_pre: assert property (p_mac_pre) else $error("mac pre");
   property p_ofs_wb;
      req_valid && ofs |=> !wb_en;
   endproperty
   a_ofs_wb: assert property (p_ofs_wb) else $error("ofs wb");
   property p_post_ea;
      (mv || mcu) && req_mode == agu_pkg::MODE_POST |=>
         ea_valid && wb_en && ea == $past(req_ptr);
   endproperty
   a_post_ea: assert property (p_post_ea) else $error("post ea");
   property p_move_idx;
      mv && ofs |=> ea_valid && !ea_error;
   endproperty
   a_move_idx: assert property (p_move_idx) else $error("idx");
   property p_interrupt_disable_instruction;
      lit && req_interrupt_disable_instruction |=> lit_valid && lit_value == ($past(req_lit) & 16'h3fff);
   endproperty
   a_interrupt_disable_instruction: assert property (p_interrupt_disable_instruction) else $error("interrupt_disable_instruction lit");
   property p_jump;
      lit && !req_interrupt_disable_instruction |=> lit_valid && lit_value == $past(req_lit);
   endproperty
   a_jump: assert property (p_jump) else $error("jump lit");
endmodule // agu_chk

// *** testbench/agu_partner.sv ***
// request source standing in for the instruction decoder
`timescale 1ns/1ps
module agu_partner (
   input wire logic aclk,
   output logic req_valid,
   output agu_pkg::class_t req_class,
   output agu_pkg::unit_t req_unit,
   output agu_pkg::mode_t req_mode,
   output logic [3:0] req_reg,
   output logic [15:0] req_ptr,
   output logic [15:0] req_index,
   output logic [15:0] req_mod,
   output logic req_interrupt_disable_instruction,
   output logic req_byte,
   output logic [15:0] req_lit
);
   initial begin
      {req_valid, req_reg, req_ptr, req_index, req_mod, req_interrupt_disable_instruction} = '0;
      req_byte = 1'b0;
      req_class = agu_pkg::CLS_MCU;
      req_unit = agu_pkg::UNIT_X_READ;
      req_mode = agu_pkg::MODE_IND;
      req_lit = '0;
   end
   // pointers kept in their own space
   // every class takes p as literal, x[0] as disable flag, x[1] as byte flag
   task automatic issue(input logic [1:0] c, u, input logic [2:0] m,
      input logic [3:0] r, input logic [15:0] p, x, d);
      @(posedge aclk);
      req_valid <= 1'b1;
      req_class <= agu_pkg::class_t'(c);
      req_unit <= agu_pkg::unit_t'(u);
      req_mode <= agu_pkg::mode_t'(m);
      {req_reg, req_ptr, req_index, req_mod} <= {r, p, x, d};
      {req_lit, req_interrupt_disable_instruction, req_byte} <= {p, x[0], x[1]};
      @(posedge aclk);
      req_valid <= 1'b0;
      // released pointer, index, modifier and literal show no stale value
      {req_ptr, req_index, req_mod, req_lit} <= ~{p, x, d, p};
      #1;
   endtask
endmodule // agu_partner

// *** testbench/tb.sv ***
// self-checking bench for the operand address generator
`timescale 1ns/1ps
module tb;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb, req_reg, wb_reg;
   logic [1:0] bresp, rresp, resp;
   logic req_valid, req_interrupt_disable_instruction, req_byte, ea_valid, ea_error, wb_en, lit_valid;
   agu_pkg::class_t req_class;
   agu_pkg::unit_t req_unit, ea_unit;
   agu_pkg::mode_t req_mode;
   logic [15:0] req_ptr, req_index, req_mod, req_lit, ea, wb_value, lit_value;
   int n_errors = 0;
   int comparisons = 0;
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   operand_address_generator operand_address_generator_inst (.*);
   agu_partner agu_partner_inst (.*);
   // ----
   // helpers
   // ----
   task chk(input string nm, input logic [31:0] s, e);
      comparisons++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
      do @(posedge aclk); while (awready !== 1'b1);
      {awvalid, wvalid} <= 2'b00;
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task axr(input logic [7:0] a);
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      {rd, resp} = {rdata, rresp};
      rready <= 1'b0;
   endtask
   task rq(input logic [1:0] c, u, input logic [2:0] m, input logic [3:0] r,
      input logic [15:0] p, x, d, e, w, input logic en);
      agu_partner_inst.issue(c, u, m, r, p, x, d);
      chk("ea", ea, e);
      chk("wb_value", wb_value, w);
      chk("wb_en", wb_en, en);
      chk("ea_valid", ea_valid, 1'b1);
      chk("wb_reg", wb_reg, r);
   endtask
   task bad(input logic [2:0] m, input logic [3:0] r, input logic [15:0] d);
      agu_partner_inst.issue(2'h2, 2'h0, m, r, 16'h0100, 16'h0000, d);
      chk("ea_error", ea_error, 1'b1);
      chk("ea_valid", ea_valid, 1'b0);
   endtask
   task conclude();
      if (n_errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #500_000;
      n_errors++;
      conclude();
   end
   // ----
   // tests
   // ----
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      axr(agu_pkg::CTRL_OFF);
      chk("ctrl", rd, 32'h0000_0fff);
      axr(agu_pkg::Y_END_OFF);
      chk("y_end", rd, 32'h0000_0000);
      axr(8'h1c);
      chk("rresp", resp, agu_pkg::RESP_SLVERR);
      axw(8'h1c, 32'h0000_0001);
      chk("bresp", resp, agu_pkg::RESP_SLVERR);
      axw(agu_pkg::X_START_OFF, 32'h0000_1000);
      axw(agu_pkg::X_END_OFF, 32'h0000_101f);
      axw(agu_pkg::Y_START_OFF, 32'h0000_2000);
      axw(agu_pkg::Y_END_OFF, 32'h0000_201f);
      axr(agu_pkg::X_END_OFF);
      chk("x_end", rd, 32'h0000_101f);
      axw(agu_pkg::CTRL_OFF, 32'h0000_8002);
      rq(1, 0, 2, 2, 16'h101e, 0, 16'h0004, 16'h1002, 16'h1002, 1);
      rq(1, 0, 2, 2, 16'h1000, 0, 16'hfffc, 16'h101c, 16'h101c, 1);
      rq(1, 1, 3, 2, 16'h101e, 4, 0, 16'h1002, 16'h1002, 0);
      rq(0, 0, 1, 2, 16'h101e, 0, 16'h0004, 16'h101e, 16'h1002, 1);
      rq(0, 0, 2, 3, 16'h101e, 0, 16'h0004, 16'h1022, 16'h1022, 1);
      rq(0, 0, 2, 2, 16'h1010, 0, 16'h0018, 16'h1008, 16'h1008, 1);
      rq(1, 0, 4, 2, 16'h101e, 0, 16'h0004, 16'h1002, 16'h1002, 0);
      agu_partner_inst.issue(0, 0, 3, 2, 16'h1000, 4, 0);
      chk("ea_error", ea_error, 1'b1);
      axw(agu_pkg::CTRL_OFF, 32'h0000_800f);
      rq(0, 0, 2, 15, 16'h101e, 0, 16'h0004, 16'h1022, 16'h1022, 1);
      axw(agu_pkg::CTRL_OFF, 32'h0000_0002);
      rq(0, 0, 2, 2, 16'h101e, 0, 16'h0004, 16'h1022, 16'h1022, 1);
      axw(agu_pkg::CTRL_OFF, 32'h0000_4020);
      rq(1, 2, 2, 2, 16'h201e, 0, 16'h0003, 16'h2000, 16'h2000, 1);
      rq(2, 2, 1, 8, 16'h0100, 0, 16'h0002, 16'h0100, 16'h0102, 1);
      chk("ea_unit", ea_unit, agu_pkg::UNIT_X_READ);
      rq(2, 0, 1, 10, 16'h2000, 0, 16'h0006, 16'h2000, 16'h2006, 1);
      chk("ea_unit", ea_unit, agu_pkg::UNIT_Y);
      rq(2, 0, 3, 11, 16'h2000, 4, 0, 16'h2004, 16'h2004, 0);
      rq(2, 1, 0, 9, 16'h0200, 0, 0, 16'h0200, 16'h0200, 0);
      chk("ea_unit", ea_unit, agu_pkg::UNIT_X_READ);
      rq(2, 0, 0, 11, 16'h2010, 0, 0, 16'h2010, 16'h2010, 0);
      chk("ea_unit", ea_unit, agu_pkg::UNIT_Y);
      bad(3'h0, 4'h7, 16'h0000);
      bad(3'h3, 4'h8, 16'h0000);
      bad(3'h2, 4'h9, 16'h0002);
      bad(3'h4, 4'h8, 16'h0002);
      bad(3'h1, 4'h8, 16'h0008);
      axw(agu_pkg::CTRL_OFF, 32'h0000_82f2);
      axw(agu_pkg::REV_CTRL_OFF, 32'h0000_8008);
      rq(1, 1, 2, 2, 16'h1010, 0, 16'h0010, 16'h1008, 16'h1008, 1);
      rq(1, 1, 2, 2, 16'h1010, 2, 16'h0010, 16'h1000, 16'h1000, 1);
      rq(1, 0, 2, 2, 16'h1010, 0, 16'h0010, 16'h1000, 16'h1000, 1);
      rq(1, 1, 3, 2, 16'h1010, 16'h0010, 0, 16'h1000, 16'h1000, 0);
      rq(1, 2, 2, 2, 16'h1010, 0, 16'h0010, 16'h1020, 16'h1020, 1);
      agu_partner_inst.issue(3, 0, 0, 0, 16'h8001, 0, 0);
      chk("lit_value", lit_value, 16'h8001);
      agu_partner_inst.issue(3, 0, 0, 0, 16'hffff, 1, 0);
      chk("lit_value", lit_value, 16'h3fff);
      conclude();
   end
endmodule // tb
bind operand_address_generator agu_chk #(.W(W)) agu_chk_inst (.*);
